//--- logic/safety_pkg.sv
// Constants and types for the safety fault and stop manager
//
// Summary of operation
// - General faults reported, standard acknowledge clears them
// - Discrepant input reads zero until fail-safe acknowledge
// - Cross-check or speed violation raises internal event
// - Internal event cleared only by fail-safe acknowledge
// - Immediate stop removes torque, no braking
// - Ramped stop brakes to standstill, then torque off
// - Torque control switched to speed control while braking
// - Braking off ramp aborts to immediate torque off
// - Cross-check cause escalates straight to torque off
// - Alarm cause: none, torque off, or ramp
// - Input pulse low-high-low plus standard acknowledge
// - Control word 0 bit 7 pulse plus acknowledge
// - Torque-off or stop-one toggle high-low-high also acknowledges
// - Power-on reset clears all faults
// - Discrepancy selects its safety function at once
// - Basic modes: torque-off discrepancy fault per channel
// - Basic modes: torque-off discrepancy flags internal event bit
// - Extended onboard: discrepancy alarm per channel
// - Stop-one discrepancy reported in extended onboard mode only, braking continues
// - Limited speed held until cleared and acknowledged
// - Direction monitoring held, motor not switched off
`default_nettype none
package safety_pkg;
	// ========================================
	// Inputs and register map
	localparam int NUM_IN  = 5;
	localparam int IDX_STO = 0;
	localparam int IDX_SS1 = 1;
	localparam int IDX_SLS = 2;
	localparam int IDX_SDI = 3;
	localparam int IDX_ACK = 4;
	localparam int AW      = 4;
	localparam int DW      = 32;
	localparam logic [AW-1:0] ADDR_CTRL   = 4'h0;
	localparam logic [AW-1:0] ADDR_STATUS = 4'h4;
	localparam logic [AW-1:0] ADDR_CODES  = 4'h8;
	localparam int CTRL_ACK_BIT  = 0;
	localparam int CTRL_MODE_LSB = 1;
	// ========================================
	// Timing
	localparam int CLK_HZ      = 10000000;
	localparam int TOL_TIME_US = 1000;
	localparam int TOL_CYCLES  = TOL_TIME_US * (CLK_HZ / 1000000);
	localparam int TOL_W       = 16;
	// Bit 0 ack input, bit 1 control word 0: low-high-low; others high-low-high
	localparam logic [5:0] SEQ_POL = 6'h03;
	// ========================================
	// Types
	typedef enum logic [1:0] {MODE_BASIC_ONBOARD, MODE_BASIC_BUS, MODE_EXT_ONBOARD,
		MODE_EXT_BUS_BASIC} mode_e;
	typedef enum logic [1:0] {STOP_RUN, STOP_RAMP, STOP_TORQUE_OFF} stop_e;
	typedef struct packed {
		logic xcheck;
		logic speed_limit;
		logic alarm_cause;
		logic standstill;
		logic ramp_violation;
		logic torque_ctrl;
		logic param_invalid;
		logic accept_test;
	} event_in_s;
	typedef struct packed {
		logic cw0_ack;
		logic cw1_sto;
		logic cw1_ss1;
	} telegram_s;
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          wr;
		logic          rd;
	} bus_req_s;
	typedef struct packed {
		logic torque_off;
		logic fast_ramp_off;
		logic force_speed_ctrl;
	} drive_s;
	typedef struct packed {
		logic safe_torque_off;
		logic ss1;
		logic safely_limited_speed;
		logic safe_direction;
	} select_s;
	typedef struct packed {
		logic fault_ch1;
		logic fault_ch2;
		logic alarm_ch1;
		logic alarm_ch2;
		logic internal_event;
		logic general_fault;
	} report_s;
	typedef struct packed {
		logic [NUM_IN-1:0][1:0]       s1;
		logic [NUM_IN-1:0][1:0]       s2;
		logic [NUM_IN-1:0][1:0]       s3;
		logic [NUM_IN-1:0][1:0]       filt;
		logic [NUM_IN-1:0]            disc;
		logic [NUM_IN-1:0]            rep;
		logic [NUM_IN-1:0]            chan2;
		logic [NUM_IN-1:0][TOL_W-1:0] tol;
		logic [5:0]                   mark;
		logic [5:0]                   lvl_prev;
		logic                         fs_armed;
		mode_e                        mode;
		stop_e                        stop;
		drive_s                       drive;
		select_s                      sel;
		report_s                      report;
		logic [DW-1:0]                rd_data;
	} state_s;
	localparam state_s STATE_RST = '0;
endpackage : safety_pkg
`default_nettype wire

//--- logic/safety_fault_stop_manager.sv
// Safety fault sorting, stop responses and fail-safe acknowledge detection
`timescale 1ns/100ps
`default_nettype none
module safety_fault_stop_manager #(
	parameter int TOL_CYCLES = safety_pkg::TOL_CYCLES
) (
	input  wire logic                                     clk,
	input  wire logic                                     rst,
	input  wire logic [safety_pkg::NUM_IN-1:0][1:0]       fs_in,
	input  wire safety_pkg::telegram_s                    tel,
	input  wire safety_pkg::event_in_s                    ev,
	input  wire safety_pkg::bus_req_s                     bus,
	output logic      [safety_pkg::DW-1:0]                rd_data,
	output safety_pkg::select_s                           sel,
	output safety_pkg::drive_s                            drive,
	output safety_pkg::report_s                           report
);
	import safety_pkg::*;

	state_s      st;
	state_s      n;
	logic        std_ack;
	logic        fs_ack;
	logic        arm;
	logic        basic;
	logic        any_sel;
	logic        to_now;
	logic        ramp_now;
	logic        ie_set;
	logic [5:0]  lvl;
	logic [NUM_IN-1:0] mism;
	logic [NUM_IN-1:0] eff;
	logic [NUM_IN-1:0] eff_n;

	// Returns {next mark, done}; pol is the level of the middle phase
	function automatic logic [1:0] seq_step(input logic prev, input logic cur,
		input logic mark, input logic pol);
		logic first;
		logic back;
		first = (cur == pol) && (prev != pol);
		back  = (cur != pol) && (prev == pol);
		return {first ? 1'b1 : (back ? 1'b0 : mark), back && mark};
	endfunction : seq_step

	// ========================================
	// Next state
	always_comb begin
		logic [1:0] r;
		logic       allow;
		r     = '0;
		allow = 1'b0;
		n     = st;
		std_ack = bus.wr && (bus.addr == ADDR_CTRL) && bus.wdata[CTRL_ACK_BIT];
		basic = (st.mode != MODE_EXT_ONBOARD);
		any_sel = st.sel.safe_torque_off || st.sel.ss1 || st.sel.safely_limited_speed || st.sel.safe_direction;

		// Three-stage sync; a level counts once stages two and three agree
		n.s1 = fs_in;
		n.s2 = st.s1;
		n.s3 = st.s2;
		for (int i = 0; i < NUM_IN; i++) begin
			for (int c = 0; c < 2; c++) begin
				if (st.s2[i][c] == st.s3[i][c]) begin
					n.filt[i][c] = st.s3[i][c];
				end
			end
			mism[i] = st.filt[i][0] != st.filt[i][1];
			eff[i]  = !st.disc[i] && st.filt[i][0] && st.filt[i][1];
		end

		// Acknowledge sequences on filtered pin levels and raw telegram bits
		lvl = {st.filt[IDX_SS1][0] & st.filt[IDX_SS1][1],
			st.filt[IDX_STO][0] & st.filt[IDX_STO][1],
			tel.cw1_ss1, tel.cw1_sto, tel.cw0_ack, eff[IDX_ACK]};
		arm = 1'b0;
		for (int k = 0; k < 6; k++) begin
			r = seq_step(st.lvl_prev[k], lvl[k], st.mark[k], SEQ_POL[k]);
			n.mark[k] = r[1];
			// Pin toggle acknowledge in extended onboard mode is blocked by a torque-off or stop-one discrepancy
			allow = (k < 4) || basic || !(st.disc[IDX_STO] || st.disc[IDX_SS1]);
			if (r[0] && allow) begin
				arm = 1'b1;
			end
		end
		n.lvl_prev = lvl;
		fs_ack = st.fs_armed && std_ack;
		n.fs_armed = (st.fs_armed && !fs_ack) || arm;

		// Discrepancy: latch at once, report after the tolerance time
		for (int i = 0; i < NUM_IN; i++) begin
			if (mism[i]) begin
				if (!st.disc[i]) begin
					n.chan2[i] = st.filt[i][0];
				end
				n.disc[i] = 1'b1;
				if (st.tol[i] != TOL_W'(TOL_CYCLES)) begin
					n.tol[i] = st.tol[i] + TOL_W'(1);
				end
				if (st.tol[i] == TOL_W'(TOL_CYCLES - 1)) begin
					n.rep[i] = 1'b1;
				end
			end else if (fs_ack) begin
				n.disc[i] = 1'b0;
				n.rep[i]  = 1'b0;
				n.tol[i]  = '0;
			end
		end
		for (int i = 0; i < NUM_IN; i++) begin
			eff_n[i] = !n.disc[i] && n.filt[i][0] && n.filt[i][1];
		end
		// Selection inputs are active low; a discrepant one stays selected
		n.sel.safe_torque_off = !eff_n[IDX_STO];
		n.sel.ss1 = !eff_n[IDX_SS1];
		n.sel.safely_limited_speed = !eff_n[IDX_SLS];
		n.sel.safe_direction = !eff_n[IDX_SDI];

		// Internal event: set beats clear in the same cycle
		ie_set = ev.xcheck || ev.speed_limit || (ev.alarm_cause && any_sel)
			|| (basic && n.rep[IDX_STO] && !st.rep[IDX_STO]);
		n.report.internal_event = ie_set || (st.report.internal_event && !fs_ack);
		n.report.general_fault = ev.param_invalid || ev.accept_test
			|| (st.report.general_fault && !std_ack);

		// Stop response
		to_now   = ev.xcheck || (ev.alarm_cause && st.sel.safe_torque_off);
		ramp_now = ev.speed_limit || (ev.alarm_cause && any_sel && !st.sel.safe_torque_off);
		case (st.stop)
			STOP_RUN: begin
				if (to_now) begin
					n.stop = STOP_TORQUE_OFF;
				end else if (ramp_now) begin
					n.stop = STOP_RAMP;
					n.drive.force_speed_ctrl = ev.torque_ctrl;
				end
			end
			STOP_RAMP: begin
				if (to_now || ev.standstill) begin
					n.stop = STOP_TORQUE_OFF;
				end else if (ev.ramp_violation) begin
					n.stop = STOP_TORQUE_OFF;
				end
			end
			STOP_TORQUE_OFF: begin
				if (!n.report.internal_event) begin
					n.stop = STOP_RUN;
				end
			end
			default: begin
				n.stop = STOP_TORQUE_OFF;
			end
		endcase
		// Torque-off selection overrides any braking phase
		n.drive.torque_off = (n.stop == STOP_TORQUE_OFF) || n.sel.safe_torque_off;
		n.drive.fast_ramp_off = (n.stop == STOP_RAMP) && !n.sel.safe_torque_off;
		n.drive.force_speed_ctrl = n.drive.fast_ramp_off && n.drive.force_speed_ctrl;

		// Discrepancy messages per channel
		n.report.fault_ch1 = basic && n.rep[IDX_STO] && !n.chan2[IDX_STO];
		n.report.fault_ch2 = basic && n.rep[IDX_STO] && n.chan2[IDX_STO];
		n.report.alarm_ch1 = !basic && |(n.rep[3:0] & ~n.chan2[3:0]);
		n.report.alarm_ch2 = !basic && |(n.rep[3:0] & n.chan2[3:0]);

		// Register port
		if (bus.wr && (bus.addr == ADDR_CTRL)) begin
			n.mode = mode_e'(bus.wdata[CTRL_MODE_LSB +: 2]);
		end
		n.rd_data = '0;
		if (bus.rd) begin
			case (bus.addr)
				ADDR_CTRL: n.rd_data = DW'({st.mode, 1'b0});
				ADDR_STATUS: n.rd_data = DW'({st.stop, st.rep[3:0], st.disc[3:0],
					st.fs_armed, st.report.general_fault, st.report.internal_event});
				ADDR_CODES: n.rd_data = DW'({st.report.fault_ch1, st.report.fault_ch2,
					st.report.alarm_ch1, st.report.alarm_ch2});
				default: n.rd_data = '0;
			endcase
		end
	end

	// Power-on reset is itself an acknowledge of every fault
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= STATE_RST;
		end else begin
			st <= n;
		end
	end

	assign rd_data = st.rd_data;
	assign sel     = st.sel;
	assign drive   = st.drive;
	assign report  = st.report;

	// ========================================
	// Checks
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence ack_in_done;
		st.mark[0] && st.lvl_prev[0] && !lvl[0];
	endsequence
	sequence cw0_done;
		st.mark[1] && st.lvl_prev[1] && !tel.cw0_ack;
	endsequence

	a_ack_input_seq: assert property ((ack_in_done ##1 std_ack) |-> fs_ack)
		else $error("input acknowledge pulse not taken");
	a_cw0_seq: assert property ((cw0_done ##1 std_ack) |-> fs_ack)
		else $error("telegram acknowledge pulse not taken");
	a_xcheck_stop: assert property (ev.xcheck |=> drive.torque_off && !drive.fast_ramp_off)
		else $error("cross-check fault did not remove torque");
	a_torque_no_ramp: assert property (drive.torque_off |-> !drive.fast_ramp_off)
		else $error("braking while torque is off");
	a_ramp_end: assert property ((st.stop == STOP_RAMP && ev.standstill) |=> drive.torque_off)
		else $error("standstill did not end the ramp");
	a_ramp_abort: assert property ((st.stop == STOP_RAMP && ev.ramp_violation)
		|=> st.stop == STOP_TORQUE_OFF)
		else $error("ramp violation did not abort braking");
	a_speed_mode: assert property ((st.stop == STOP_RUN && ev.speed_limit && ev.torque_ctrl
		&& !ev.xcheck && !ev.alarm_cause && !st.sel.safe_torque_off && !n.sel.safe_torque_off)
		|=> drive.force_speed_ctrl && drive.fast_ramp_off)
		else $error("speed control not forced during ramp");
	a_ie_hold: assert property ((st.report.internal_event && !std_ack)
		|=> st.report.internal_event)
		else $error("internal event cleared without acknowledge");
	a_disc_select: assert property (mism[IDX_STO] |=> sel.safe_torque_off ##1 sel.safe_torque_off)
		else $error("discrepancy did not select torque off");
	a_general_flag: assert property (ev.param_invalid |=> report.general_fault)
		else $error("general fault not reported");
	a_alarm_idle: assert property ((st.stop == STOP_RUN && ev.alarm_cause && !any_sel
		&& !ev.xcheck && !ev.speed_limit) |=> st.stop == STOP_RUN)
		else $error("alarm with no function active moved the motor");

	// ========================================
	// Further checks on flags, selections and the braking phase
	sequence cw1_done;
		st.mark[2] && !st.lvl_prev[2] && tel.cw1_sto;
	endsequence

	a_cw1_arm: assert property (cw1_done |=> st.fs_armed)
		else $error("telegram select toggle did not arm acknowledge");
	a_general_ack: assert property ((st.report.general_fault && std_ack
		&& !ev.param_invalid && !ev.accept_test) |=> !report.general_fault)
		else $error("standard acknowledge did not clear general fault");
	a_speed_event: assert property (ev.speed_limit |=> report.internal_event)
		else $error("speed violation raised no internal event");
	a_disc_hold: assert property ((st.disc[IDX_STO] && !fs_ack) |=> st.disc[IDX_STO])
		else $error("discrepancy dropped without fail-safe acknowledge");
	a_sls_held: assert property (st.disc[IDX_SLS] |-> sel.safely_limited_speed)
		else $error("limited speed released while discrepant");
	a_sto_event: assert property ((basic && n.rep[IDX_STO] && !st.rep[IDX_STO])
		|=> report.internal_event)
		else $error("torque-off discrepancy raised no internal event");
	a_ext_alarm: assert property ((!basic && n.rep[IDX_SDI] && n.chan2[IDX_SDI])
		|=> report.alarm_ch2)
		else $error("extended mode discrepancy raised no alarm");
	a_ramp_wait: assert property ((st.stop == STOP_RAMP && !ev.standstill
		&& !ev.ramp_violation && !to_now) |=> st.stop == STOP_RAMP)
		else $error("braking ended before standstill");
endmodule : safety_fault_stop_manager
`default_nettype wire

//--- tb/safety_ctrl_model.sv
// Safety controller model driving the fail-safe pins and telegram bits
`timescale 1ns/100ps
`default_nettype none
module safety_ctrl_model (
	input  wire logic                                clk,
	output var  logic [safety_pkg::NUM_IN-1:0][1:0] fs_in,
	output var  safety_pkg::telegram_s               tel
);
	import safety_pkg::*;
	// ========================================
	// Idle: selects high means deselected, acknowledge low
	initial begin
		fs_in = {2'h0, 2'h3, 2'h3, 2'h3, 2'h3};
		tel = 3'h3;
	end
	// Every level held past the three-stage input synchroniser
	task automatic hold();
		repeat (6) @(posedge clk);
	endtask : hold
	task automatic set_pin(input int idx, input logic [1:0] val);
		@(posedge clk);
		fs_in[idx] <= val;
	endtask : set_pin
	task automatic ack_pin_pulse();
		set_pin(IDX_ACK, 2'h3);
		hold();
		set_pin(IDX_ACK, 2'h0);
		hold();
	endtask : ack_pin_pulse
	task automatic cw0_pulse();
		@(posedge clk);
		tel.cw0_ack <= 1'b1;
		hold();
		tel.cw0_ack <= 1'b0;
		hold();
	endtask : cw0_pulse
	task automatic cw1_toggle();
		@(posedge clk);
		tel.cw1_sto <= 1'b0;
		hold();
		tel.cw1_sto <= 1'b1;
		hold();
	endtask : cw1_toggle
endmodule : safety_ctrl_model
`default_nettype wire

//--- tb/safety_fault_stop_manager_tb.sv
// Self-checking bench for the safety fault and stop manager
`timescale 1ns/100ps
`default_nettype none
module safety_fault_stop_manager_tb;
	import safety_pkg::*;
	logic                         clk = 1'b0;
	logic                         rst = 1'b1;
	logic [NUM_IN-1:0][1:0]       fs_in;
	telegram_s                    tel;
	event_in_s                    ev = '0;
	bus_req_s                     bus = '0;
	logic [DW-1:0]                rd_data;
	select_s                      sel;
	drive_s                       drive;
	report_s                      report;
	int                           fail_count = 0;
	int                           compares = 0;
	int                           cycles = 0;
	// ========================================
	// Clock, reset, partner and device
	always #50 clk = ~clk;
	safety_ctrl_model ctrl (.clk(clk), .fs_in(fs_in), .tel(tel));
	safety_fault_stop_manager #(.TOL_CYCLES(8)) dut (.clk(clk), .rst(rst), .fs_in(fs_in),
		.tel(tel), .ev(ev), .bus(bus), .rd_data(rd_data), .sel(sel), .drive(drive),
		.report(report));
	// ========================================
	// Shared tasks
	task automatic complete_run();
		if (fail_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fail_count = fail_count + 1;
			$display("MISMATCH %0t timeout", $time);
			complete_run();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : cyc
	task automatic ev_pulse(input logic [7:0] v);
		@(posedge clk);
		ev <= event_in_s'(v);
		@(posedge clk);
		ev <= '0;
	endtask : ev_pulse
	task automatic std_ack();
		@(posedge clk);
		bus.addr <= ADDR_CTRL;
		bus.wdata <= 32'h0000_0001;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : std_ack
	task automatic wr_mode(input logic [1:0] m);
		@(posedge clk);
		bus.addr <= ADDR_CTRL;
		bus.wdata <= {29'h0, m, 1'b0};
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask : wr_mode
	task automatic rd_check(input logic [AW-1:0] a, input logic [31:0] exp);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		check(rd_data, exp, "read data");
	endtask : rd_check
	task automatic chk_out(input logic [2:0] d, input logic [5:0] r);
		check(32'(drive), 32'(d), "drive");
		check(32'(report), 32'(r), "report");
	endtask : chk_out
	// ========================================
	// Scenarios
	task automatic s_events();
		ev_pulse(8'h03);
		cyc(2);
		chk_out(3'h0, 6'h01);
		std_ack();
		cyc(2);
		chk_out(3'h0, 6'h00);
		ev_pulse(8'h44);
		cyc(1);
		chk_out(3'h3, 6'h02);
		ev_pulse(8'h10);
		cyc(2);
		check(32'(drive), 32'h4, "ramp end");
		std_ack();
		cyc(3);
		check(32'(drive), 32'h4, "plain ack");
		ctrl.cw0_pulse();
		std_ack();
		cyc(3);
		chk_out(3'h0, 6'h00);
		ev_pulse(8'h80);
		cyc(2);
		check(32'(drive), 32'h4, "xcheck");
		ctrl.ack_pin_pulse();
		std_ack();
		cyc(3);
		chk_out(3'h0, 6'h00);
		ev_pulse(8'h40);
		cyc(3);
		ev_pulse(8'h08);
		cyc(2);
		check(32'(drive), 32'h4, "abort");
		ctrl.cw1_toggle();
		std_ack();
		cyc(3);
		chk_out(3'h0, 6'h00);
	endtask : s_events
	task automatic s_alarm();
		ev_pulse(8'h20);
		cyc(2);
		check(32'(drive), 32'h0, "alarm idle");
		ctrl.set_pin(IDX_STO, 2'h0);
		cyc(6);
		ev_pulse(8'h20);
		cyc(2);
		check(32'(drive), 32'h4, "alarm sto");
		ctrl.set_pin(IDX_STO, 2'h3);
		cyc(6);
		std_ack();
		cyc(3);
		check(32'(drive), 32'h0, "pin toggle");
	endtask : s_alarm
	task automatic s_disc();
		ctrl.set_pin(IDX_STO, 2'h1);
		cyc(5);
		check(32'(sel.safe_torque_off), 32'h1, "select");
		cyc(12);
		check(32'(report), 32'h12, "disc report");
		ctrl.set_pin(IDX_STO, 2'h3);
		cyc(6);
		check(32'(sel.safe_torque_off), 32'h1, "held");
		ctrl.cw0_pulse();
		std_ack();
		cyc(6);
		check(32'(report), 32'h0, "cleared");
	endtask : s_disc
	task automatic s_ext();
		wr_mode(2'h2);
		ctrl.set_pin(IDX_SLS, 2'h2);
		ctrl.set_pin(IDX_SDI, 2'h1);
		cyc(5);
		check(32'(sel), 32'h3, "ext select");
		cyc(12);
		check(32'(report), 32'h0C, "ext alarms");
		check(32'(drive), 32'h0, "motor kept");
		rd_check(ADDR_CODES, 32'h3);
		ctrl.set_pin(IDX_SLS, 2'h3);
		ctrl.set_pin(IDX_SDI, 2'h3);
		cyc(6);
		check(32'(sel), 32'h3, "ext held");
		ctrl.ack_pin_pulse();
		std_ack();
		cyc(3);
		check(32'(sel), 32'h0, "ext released");
		check(32'(report), 32'h0, "ext cleared");
	endtask : s_ext
	task automatic s_reset();
		ev_pulse(8'h80);
		@(posedge clk);
		rst <= 1'b1;
		cyc(2);
		check(32'(drive), 32'h0, "in reset");
		@(posedge clk);
		rst <= 1'b0;
		cyc(8);
		chk_out(3'h0, 6'h00);
		rd_check(ADDR_STATUS, 32'h0);
	endtask : s_reset
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		cyc(8);
		chk_out(3'h0, 6'h00);
		rd_check(ADDR_STATUS, 32'h0);
		rd_check(4'hC, 32'h0);
		s_events();
		s_alarm();
		s_disc();
		s_ext();
		s_reset();
		complete_run();
	end
endmodule : safety_fault_stop_manager_tb
`default_nettype wire
